// File: core/fhb_params.svh
// Purpose: Shared constants of the flash host bus control block
// Assumes: 50 MHz core clock sampling every host pin
// Notes: Included by the package and the top module only
`ifndef FHB_PARAMS_SVH
`define FHB_PARAMS_SVH

`define FHB_CLK_PERIOD_NS 20
`define FHB_ADDR_W 16
`define FHB_DATA_W 16
`define FHB_RAM_AW 12
`define FHB_LAT_W 4
`define FHB_LATENCY 4'h4
`define FHB_PU_W 8
`define FHB_POWERUP_CYC 8'h10
`define FHB_CTRL_W 6
`define FHB_CTRL_IDLE 6'h3f
`define FHB_ADDR_ZERO 16'h0000
`define FHB_DATA_ZERO 16'h0000

`endif

// File: core/fhb_pkg.sv
// Purpose: Types of the flash host bus control block
// Assumes: Constants come from fhb_params.svh
// Notes: Nothing here is imported; users write fhb_pkg::name
`include "fhb_params.svh"

package fhb_pkg;

	typedef enum logic [2:0] {
		FHB_IDLE = 3'b001,
		FHB_WAIT = 3'b010,
		FHB_BURST = 3'b100
	} fhb_burst_t;

	typedef struct packed {
		logic prev_bclk;
		logic prev_avd_n;
		logic prev_we_n;
		logic [`FHB_ADDR_W-1:0] addr;
		fhb_burst_t fsm;
		logic [`FHB_LAT_W-1:0] lat_cnt;
		logic [`FHB_PU_W-1:0] pu_cnt;
		logic powered;
		logic [`FHB_DATA_W-1:0] dq_out;
		logic dq_oe;
		logic rdy;
		logic rdy_oe;
		logic int_oe;
		logic standby;
	} fhb_state_t;

endpackage

// File: core/fhb_ram_if.sv
// Purpose: Port between the control logic and the host buffer RAM
// Assumes: One write and one registered read per core clock
// Notes: Plain signals, no clocking block
`timescale 1ns/100ps

interface fhb_ram_if #(
	parameter int ADDR_W = 16,
	parameter int DATA_W = 16
);
	logic we;
	logic [ADDR_W-1:0] waddr;
	logic [DATA_W-1:0] wdata;
	logic [ADDR_W-1:0] raddr;
	logic [DATA_W-1:0] rdata;

	modport ctrl(output we, output waddr, output wdata, output raddr, input rdata);
	modport ram(input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// File: core/fhb_sync.sv
// Purpose: Two-flop synchroniser for host pins
// Assumes: Pins are stable for several core clocks around use
// Notes: Stage one feeds stage two and nothing else
`timescale 1ns/100ps

module fhb_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} fhb_sync_t;

	fhb_sync_t st;
	fhb_sync_t next_st;

	always_comb begin
		next_st.s1 = i_d;
		next_st.s2 = st.s1;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			st <= {RST_VAL, RST_VAL};
		end else begin
			st <= next_st;
		end
	end

	assign o_q = st.s2;
endmodule

// File: core/fhb_buffer_ram.sv
// Purpose: Host buffer RAM word store with registered read
// Assumes: Addresses above the implemented depth read zero
// Notes: Writes outside the depth are dropped
`timescale 1ns/100ps

module fhb_buffer_ram #(
	parameter int ADDR_W = 16,
	parameter int DATA_W = 16,
	parameter int RAM_AW = 12
) (
	input wire logic i_clk,
	fhb_ram_if.ram mem
);
	typedef struct packed {
		logic [DATA_W-1:0] rdata;
	} fhb_ram_t;

	logic [DATA_W-1:0] store [0:(1<<RAM_AW)-1];
	fhb_ram_t st;
	fhb_ram_t next_st;
	logic rhit;
	logic whit;

	always_comb begin
		rhit = (mem.raddr[ADDR_W-1:RAM_AW] == '0);
		whit = (mem.waddr[ADDR_W-1:RAM_AW] == '0);
		next_st.rdata = rhit ? store[mem.raddr[RAM_AW-1:0]] : '0;
	end

	always_ff @(posedge i_clk) begin
		st <= next_st;
		if (mem.we && whit) begin
			store[mem.waddr[RAM_AW-1:0]] <= mem.wdata;
		end
	end

	assign mem.rdata = st.rdata;
endmodule

// File: core/fhb_host_port.sv
// Purpose: Control pins of the parallel host port of a flash device
// Assumes: Host bus clock well below a quarter of the 50 MHz core clock
// Notes: Every host pin passes two flops; data bus and ready are three-signal pins
`timescale 1ns/100ps
`include "fhb_params.svh"

module fhb_host_port #(
	parameter logic [`FHB_LAT_W-1:0] LATENCY = `FHB_LATENCY,
	parameter logic [`FHB_PU_W-1:0] POWERUP_CYC = `FHB_POWERUP_CYC,
	parameter int RAM_AW = `FHB_RAM_AW
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_bus_clk,
	input wire logic i_address_latch_strobe_n,
	input wire logic i_chip_enable_n,
	input wire logic i_output_enable_n,
	input wire logic i_write_strobe_n,
	input wire logic i_hard_reset_n,
	input wire logic [`FHB_ADDR_W-1:0] i_address_inputs,
	input wire logic [`FHB_DATA_W-1:0] i_data_bus,
	input wire logic i_sync_mode,
	input wire logic i_boot_loading,
	input wire logic i_cmd_done,
	input wire logic i_int_enable,
	output logic [`FHB_DATA_W-1:0] o_data_bus,
	output logic o_data_bus_oe,
	output logic o_data_valid,
	output logic o_data_valid_oe,
	output logic o_int,
	output logic o_int_oe,
	output logic o_standby
);
	fhb_pkg::fhb_state_t st;
	fhb_pkg::fhb_state_t next_st;

	logic [`FHB_CTRL_W-1:0] ctrl_sync;
	logic [`FHB_ADDR_W+`FHB_DATA_W-1:0] bus_sync;
	logic s_bclk;
	logic s_avd_n;
	logic s_ce_n;
	logic s_oe_n;
	logic s_we_n;
	logic s_rp_n;
	logic [`FHB_ADDR_W-1:0] s_addr;
	logic [`FHB_DATA_W-1:0] s_data;
	logic bclk_rise;
	logic avd_rise;
	logic we_rise;
	logic int_rst;
	logic [`FHB_ADDR_W-1:0] cur_addr;

	fhb_ram_if #(.ADDR_W(`FHB_ADDR_W), .DATA_W(`FHB_DATA_W)) mem ();

	fhb_sync #(.W(`FHB_CTRL_W), .RST_VAL(`FHB_CTRL_IDLE)) u_ctrl_sync (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_d({i_bus_clk, i_address_latch_strobe_n, i_chip_enable_n,
			i_output_enable_n, i_write_strobe_n, i_hard_reset_n}),
		.o_q(ctrl_sync)
	);

	fhb_sync #(.W(`FHB_ADDR_W+`FHB_DATA_W), .RST_VAL('0)) u_bus_sync (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_d({i_address_inputs, i_data_bus}),
		.o_q(bus_sync)
	);

	fhb_buffer_ram #(.ADDR_W(`FHB_ADDR_W), .DATA_W(`FHB_DATA_W), .RAM_AW(RAM_AW)) u_ram (
		.i_clk(i_clk),
		.mem(mem.ram)
	);

	assign {s_bclk, s_avd_n, s_ce_n, s_oe_n, s_we_n, s_rp_n} = ctrl_sync;
	assign s_addr = bus_sync[`FHB_ADDR_W+`FHB_DATA_W-1:`FHB_DATA_W];
	assign s_data = bus_sync[`FHB_DATA_W-1:0];

	always_comb begin
		next_st = st;
		bclk_rise = s_bclk && !st.prev_bclk;
		avd_rise = s_avd_n && !st.prev_avd_n;
		we_rise = s_we_n && !st.prev_we_n;
		// Pin ignored until the power-up window closes and boot load ends
		int_rst = st.powered && !i_boot_loading && !s_rp_n;
		// Strobe low: live address valid; high: latched one only
		cur_addr = !s_avd_n ? s_addr : st.addr;
		next_st.prev_bclk = s_bclk;
		next_st.prev_avd_n = s_avd_n;
		next_st.prev_we_n = s_we_n;
		if (!st.powered) begin
			next_st.pu_cnt = st.pu_cnt + 1'b1;
			next_st.powered = (st.pu_cnt == POWERUP_CYC - 1'b1);
		end
		next_st.standby = s_ce_n;
		next_st.dq_out = mem.rdata;
		// Never drive against a host write
		next_st.dq_oe = !s_ce_n && !s_oe_n && s_we_n && !int_rst;
		next_st.rdy_oe = !s_ce_n && !int_rst;
		// Interrupt floats until enabled, then pulls low while busy
		next_st.int_oe = st.powered && i_int_enable && !i_cmd_done;
		mem.we = 1'b0;
		mem.waddr = cur_addr;
		mem.wdata = s_data;
		mem.raddr = cur_addr;
		if (int_rst) begin
			next_st.fsm = fhb_pkg::FHB_IDLE;
			next_st.addr = `FHB_ADDR_ZERO;
			next_st.lat_cnt = '0;
			next_st.rdy = 1'b0;
		end else if (s_ce_n) begin
			// Standby drops any burst in flight
			next_st.fsm = fhb_pkg::FHB_IDLE;
			next_st.rdy = 1'b0;
		end else begin
			// Selected: respond to bus cycles
			mem.we = we_rise;
			if (!i_sync_mode && avd_rise) begin
				next_st.addr = s_addr;
			end
			case (st.fsm)
				fhb_pkg::FHB_IDLE: begin
					if (i_sync_mode && bclk_rise && !s_avd_n) begin
						next_st.addr = s_addr;
						next_st.lat_cnt = LATENCY;
						next_st.fsm = fhb_pkg::FHB_WAIT;
					end
				end
				fhb_pkg::FHB_WAIT: begin
					if (bclk_rise) begin
						if (st.lat_cnt <= 1) begin
							next_st.fsm = fhb_pkg::FHB_BURST;
							next_st.rdy = 1'b1;
						end else begin
							next_st.lat_cnt = st.lat_cnt - 1'b1;
						end
					end
				end
				fhb_pkg::FHB_BURST: begin
					if (bclk_rise) begin
						if (!s_avd_n) begin
							// New start address restarts the latency
							next_st.addr = s_addr;
							next_st.lat_cnt = LATENCY;
							next_st.rdy = 1'b0;
							next_st.fsm = fhb_pkg::FHB_WAIT;
						end else begin
							next_st.addr = st.addr + 1'b1;
						end
					end
				end
				default: begin
					next_st.fsm = fhb_pkg::FHB_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			st <= '{prev_bclk: 1'b0, prev_avd_n: 1'b1, prev_we_n: 1'b1,
				addr: `FHB_ADDR_ZERO, fsm: fhb_pkg::FHB_IDLE, lat_cnt: '0,
				pu_cnt: '0, powered: 1'b0, dq_out: `FHB_DATA_ZERO, dq_oe: 1'b0,
				rdy: 1'b0, rdy_oe: 1'b0, int_oe: 1'b0, standby: 1'b1};
		end else begin
			st <= next_st;
		end
	end

	assign o_data_bus = st.dq_out;
	assign o_data_bus_oe = st.dq_oe;
	assign o_data_valid = st.rdy;
	assign o_data_valid_oe = st.rdy_oe;
	// Open drain: only ever pulls low
	assign o_int = 1'b0;
	assign o_int_oe = st.int_oe;
	assign o_standby = st.standby;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	property p_rdy_ce;
		o_data_valid_oe |-> !$past(s_ce_n);
	endproperty
	a_rdy_ce: assert property (p_rdy_ce) else $error("ready driven while deselected");

	property p_sync_latch;
		(st.fsm == fhb_pkg::FHB_IDLE && i_sync_mode && bclk_rise && !s_avd_n
			&& !s_ce_n && !int_rst) |=> (st.addr == $past(s_addr))
			&& st.fsm == fhb_pkg::FHB_WAIT;
	endproperty
	a_sync_latch: assert property (p_sync_latch) else $error("burst start not latched");

	property p_async_latch;
		(!i_sync_mode && avd_rise && !s_ce_n && !int_rst) |=> st.addr == $past(s_addr);
	endproperty
	a_async_latch: assert property (p_async_latch) else $error("async address lost");

	property p_avd_ignore;
		(s_avd_n && !avd_rise && st.fsm != fhb_pkg::FHB_BURST && !int_rst)
			|=> $stable(st.addr);
	endproperty
	a_avd_ignore: assert property (p_avd_ignore) else $error("address taken while strobe high");

	property p_write;
		(we_rise && !s_ce_n && !int_rst) |-> mem.we && mem.wdata == s_data
			&& mem.waddr == cur_addr;
	endproperty
	a_write: assert property (p_write) else $error("write edge not stored");

	property p_hard_reset;
		int_rst |=> st.fsm == fhb_pkg::FHB_IDLE && !o_data_bus_oe && !o_data_valid;
	endproperty
	a_hard_reset: assert property (p_hard_reset) else $error("hard reset not obeyed");

	property p_boot_ignore;
		(st.fsm == fhb_pkg::FHB_BURST && i_boot_loading && !s_ce_n)
			|=> st.fsm != fhb_pkg::FHB_IDLE;
	endproperty
	a_boot_ignore: assert property (p_boot_ignore) else $error("reset acted during boot load");

	property p_standby;
		s_ce_n |=> o_standby && !o_data_bus_oe && !o_data_valid_oe;
	endproperty
	a_standby: assert property (p_standby) else $error("bus driven in standby");

	property p_oe_gate;
		o_data_bus_oe |-> !$past(s_oe_n) && !$past(s_ce_n);
	endproperty
	a_oe_gate: assert property (p_oe_gate) else $error("drivers on without output enable");

	property p_int_float;
		!i_int_enable |=> !o_int_oe;
	endproperty
	a_int_float: assert property (p_int_float) else $error("interrupt driven before enable");
endmodule

// File: dv/fhb_host_model.sv
// Purpose: Host memory controller model driving the flash host pins
// Assumes: Tasks are entered at a falling core clock edge
// Notes: Released data shows the inverted last word, never a stale copy
`timescale 1ns/100ps
module fhb_host_model (
	input wire logic i_clk,
	output logic o_bus_clk,
	output logic o_avd_n,
	output logic o_ce_n,
	output logic o_oe_n,
	output logic o_we_n,
	output logic o_rst_n,
	output logic [15:0] o_addr,
	output logic [15:0] o_data
);
	initial begin
		// Hard reset pin idles high, else writes are refused once powered
		{o_bus_clk, o_avd_n, o_ce_n, o_oe_n, o_we_n, o_rst_n} = 6'h1f;
		{o_addr, o_data} = {16'h0000, 16'hffff};
	end
	task automatic wt(input int n);
		repeat (n) @(negedge i_clk);
	endtask
	task automatic pins(input logic ce_n, input logic oe_n, input logic rst_n);
		{o_ce_n, o_oe_n, o_rst_n} = {ce_n, oe_n, rst_n};
		wt(6);
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		{o_ce_n, o_avd_n, o_we_n, o_addr, o_data} = {3'b000, a, d};
		wt(5);
		o_we_n = 1'b1; // Data still held at the rising edge
		wt(5);
		{o_avd_n, o_data} = {1'b1, ~d};
		wt(1);
	endtask
	task automatic rd(input logic [15:0] a);
		{o_ce_n, o_oe_n, o_avd_n, o_addr} = {3'b000, a};
		wt(6);
		o_avd_n = 1'b1;
		wt(4);
		o_addr = ~a;
		wt(6);
	endtask
	// Bus clock only moves inside a burst
	task automatic bclk(input int n);
		repeat (n) begin
			o_bus_clk = 1'b1;
			wt(4);
			o_bus_clk = 1'b0;
			wt(4);
		end
	endtask
	task automatic bst(input logic [15:0] a);
		{o_ce_n, o_oe_n, o_avd_n, o_addr} = {3'b000, a};
		wt(4);
		bclk(1); // Strobe low for exactly one bus clock
		{o_avd_n, o_addr} = {1'b1, ~a};
	endtask
endmodule

// File: dv/tb_top.sv
// Purpose: Self-checking bench of the flash host port control pins
// Assumes: Host model drives pins, bench drives core-side levels
// Notes: Waits follow the three to four edge pin path latency
`timescale 1ns/100ps
module tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic sync_mode = 1'b0;
	logic boot = 1'b0;
	logic cmd_done = 1'b1;
	logic int_en = 1'b0;
	logic bclk, avd_n, ce_n, oe_n, we_n, rst_n;
	logic [15:0] addr, hdata, dq, dout;
	logic dq_oe, valid, valid_oe, irq, irq_oe, standby;
	int error_cnt = 0;
	int comparisons = 0;

	always #10 clk = ~clk;
	assign dq = dq_oe ? dout : hdata;

	fhb_host_model host (.i_clk(clk), .o_bus_clk(bclk), .o_avd_n(avd_n),
		.o_ce_n(ce_n), .o_oe_n(oe_n), .o_we_n(we_n), .o_rst_n(rst_n),
		.o_addr(addr), .o_data(hdata));

	fhb_host_port uut (.i_clk(clk), .i_rst(rst), .i_bus_clk(bclk),
		.i_address_latch_strobe_n(avd_n), .i_chip_enable_n(ce_n),
		.i_output_enable_n(oe_n), .i_write_strobe_n(we_n),
		.i_hard_reset_n(rst_n), .i_address_inputs(addr), .i_data_bus(dq),
		.i_sync_mode(sync_mode), .i_boot_loading(boot), .i_cmd_done(cmd_done),
		.i_int_enable(int_en), .o_data_bus(dout), .o_data_bus_oe(dq_oe),
		.o_data_valid(valid), .o_data_valid_oe(valid_oe), .o_int(irq),
		.o_int_oe(irq_oe), .o_standby(standby));

	task automatic chk_d(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_f(input logic got, input logic exp);
		chk_d({15'h0000, got}, {15'h0000, exp});
	endtask

	task automatic give_verdict;
		if (error_cnt == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic t_reset;
		chk_f(standby, 1'b1);
		chk_f(dq_oe, 1'b0);
		chk_f(irq_oe, 1'b0);
	endtask
	task automatic t_wr_rd;
		host.wr(16'h0012, 16'ha5c3);
		host.wr(16'h0013, 16'h3c5a);
		host.rd(16'h0012);
		chk_d(dout, 16'ha5c3);
		chk_f(dq_oe, 1'b1);
		host.rd(16'h0013);
		chk_d(dout, 16'h3c5a);
	endtask
	task automatic t_select;
		host.pins(1'b0, 1'b1, 1'b1);
		chk_f(dq_oe, 1'b0);
		host.pins(1'b1, 1'b0, 1'b1);
		chk_f(standby, 1'b1);
		chk_f(dq_oe, 1'b0);
		host.pins(1'b0, 1'b0, 1'b1);
		chk_f(standby, 1'b0);
	endtask
	task automatic t_burst;
		sync_mode = 1'b1;
		host.bst(16'h0012);
		host.bclk(3);
		chk_f(valid, 1'b0);
		chk_f(valid_oe, 1'b1);
		host.bclk(1);
		chk_f(valid, 1'b1);
		chk_d(dout, 16'ha5c3);
		host.bclk(1);
		chk_d(dout, 16'h3c5a);
	endtask
	task automatic t_hard_reset;
		boot = 1'b1;
		host.pins(1'b0, 1'b0, 1'b0);
		chk_f(valid, 1'b1);
		boot = 1'b0;
		host.wt(6);
		chk_f(valid, 1'b0);
		host.pins(1'b1, 1'b0, 1'b1);
		chk_f(valid_oe, 1'b0);
		sync_mode = 1'b0;
	endtask
	task automatic t_irq;
		{int_en, cmd_done} = 2'b10;
		host.wt(4);
		chk_f(irq_oe, 1'b1);
		chk_f(irq, 1'b0);
		cmd_done = 1'b1;
		host.wt(4);
		chk_f(irq_oe, 1'b0);
	endtask

	initial begin
		repeat (10) @(negedge clk);
		rst = 1'b0;
		host.wt(1);
		t_reset();
		host.wt(20);
		t_wr_rd();
		t_select();
		t_burst();
		t_hard_reset();
		t_irq();
		give_verdict();
	end

	// Whole sequence needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clk);
		error_cnt++;
		give_verdict();
	end
endmodule
